// ===== csm_map.vh
`ifndef CSM_MAP_VH
`define CSM_MAP_VH

// ----------------------------------------------------------------------------
// configuration space layout (dword addresses)
// ----------------------------------------------------------------------------
`define CSM_CFG_ADDR_W      10
`define CSM_CFG_RAM_AW      8
`define CSM_CFG_ID_DW       10'h000
`define CSM_CFG_RO_TOP      10'h010
`define CSM_CFG_ERR_STAT_DW 10'h040
`define CSM_CFG_ID_VALUE    32'h0a5a_0c3e  // arbitrary identity value

// ----------------------------------------------------------------------------
// error status bit positions
// ----------------------------------------------------------------------------
`define CSM_ERR_COR         0
`define CSM_ERR_ACS         1
`define CSM_ERR_ECRC        2
`define CSM_ERR_ABORT       3
`define CSM_ERR_TIMEOUT     4
`define CSM_ERR_UNEXP       5
`define CSM_ERR_UR          6
`define CSM_ERR_BITS        7
`define CSM_ERR_RESET       7'h00

// ----------------------------------------------------------------------------
// completion header fifo entry
// ----------------------------------------------------------------------------
`define CSM_HDR_W           48
`define CSM_ENT_LOCK        48
`define CSM_ENT_UR          49
`define CSM_ENT_W           50
`define CSM_FIFO_DEPTH      4
`define CSM_FIFO_PTR_W      2

// ----------------------------------------------------------------------------
// avalon word addresses and fields
// ----------------------------------------------------------------------------
`define CSM_AV_ADDR_W       3
`define CSM_AV_ERR_STAT     3'h0
`define CSM_AV_HDR_LO       3'h1
`define CSM_AV_HDR_HI       3'h2
`define CSM_AV_CTRL         3'h3
`define CSM_AV_CTRL_POP     0
`define CSM_AV_HI_LOCK      16
`define CSM_AV_HI_UR        17
`define CSM_AV_HI_VALID     31

`endif

// ===== csm_cfg_ram.v
`timescale 1ns/10ps
// byte-lane configuration store with registered read data
module csm_cfg_ram #(
  parameter ADDR_W = 8
) (
  input  wire              ref_clk,
  input  wire              wrEn,
  input  wire [3:0]        byteEn,
  input  wire [ADDR_W-1:0] addr,
  input  wire [31:0]       wrData,
  input  wire              rdEn,
  output wire [31:0]       rdData
);
  localparam DEPTH = 1 << ADDR_W;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : gLane
      reg [7:0] mem [0:DEPTH-1];
      reg [7:0] rdReg;
      integer   i;
      // cleared at load so unwritten words do not read unknown
      initial begin
        for (i = 0; i < DEPTH; i = i + 1) begin
          mem[i] = 8'h00;
        end
        rdReg = 8'h00;
      end
      // one lane per array keeps every byte with a single writer
      always @(posedge ref_clk) begin
        if (wrEn && byteEn[lane]) begin
          mem[addr] <= wrData[8*lane +: 8];
        end
        if (rdEn) begin
          rdReg <= mem[addr];
        end
      end
      assign rdData[8*lane +: 8] = rdReg;
    end
  endgenerate
endmodule

// ===== csm_hdr_fifo.v
`timescale 1ns/10ps
// small fifo for completion headers; full and empty are registered
module csm_hdr_fifo #(
  parameter WIDTH = 50,
  parameter DEPTH = 4,
  parameter PTR_W = 2
) (
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire             push,
  input  wire [WIDTH-1:0] pushData,
  input  wire             pop,
  output wire [WIDTH-1:0] headData,
  output reg              fullReg,
  output reg              emptyReg,
  output reg  [PTR_W:0]   countReg
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wrPtrReg;
  reg [PTR_W-1:0] rdPtrReg;
  wire            doPush;
  wire            doPop;
  reg  [PTR_W:0]  countNext;

  assign doPush   = push && !fullReg;
  assign doPop    = pop && !emptyReg;
  assign headData = mem[rdPtrReg];

  // occupancy after this cycle's push and pop
  always @* begin
    countNext = countReg;
    if (doPush && !doPop) begin
      countNext = countReg + {{PTR_W{1'b0}}, 1'b1};
    end else if (doPop && !doPush) begin
      countNext = countReg - {{PTR_W{1'b0}}, 1'b1};
    end
  end

  // storage has no reset; only pointers, count and flags need one
  always @(posedge ref_clk) begin
    if (doPush) begin
      mem[wrPtrReg] <= pushData;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPtrReg <= {PTR_W{1'b0}};
      rdPtrReg <= {PTR_W{1'b0}};
      countReg <= {(PTR_W+1){1'b0}};
      fullReg  <= 1'b0;
      emptyReg <= 1'b1;
    end else begin
      if (doPush) begin
        wrPtrReg <= wrPtrReg + {{(PTR_W-1){1'b0}}, 1'b1};
      end
      if (doPop) begin
        rdPtrReg <= rdPtrReg + {{(PTR_W-1){1'b0}}, 1'b1};
      end
      countReg <= countNext;
      fullReg  <= (countNext == DEPTH[PTR_W:0]);
      emptyReg <= (countNext == {(PTR_W+1){1'b0}});
    end
  end
endmodule

// ===== csm_cfg_mgmt.v
// What this block does
// RQ1 - user gives four active-low byte enables choosing bytes of the dword
// RQ2 - user gives 32-bit write data; block stores it into configuration space
// RQ3 - block returns configuration read data on a 32-bit output
// RQ4 - user gives a 10-bit dword address for each access
// RQ5 - user requests a read by driving read enable low
// RQ6 - user requests a write by driving write enable low
// RQ7 - block pulses done low on completion; for reads it validates data
// RQ8 - read-only override makes RO bits writable, except fixed, reserved, status
// RQ9 - writing one clears a W1C bit; only internal events set it
// RQ10 - W1C-as-RW qualifier lets a write store W1C bits directly
// RQ11 - user pulses ACS violation report low
// RQ12 - advanced header log input is tied to zero by the user
// RQ13 - user pulses correctable error report low
// RQ14 - aborted completion report is ignored while fifo ready is deasserted
// RQ15 - fifo ready is low only while the header fifo has room
// RQ16 - user pulses completion timeout report low
// RQ17 - user pulses unexpected completion report low
// RQ18 - user pulses end-to-end CRC error report low
// RQ19 - locked qualifier marks the queued completion as locked type
// RQ20 - posted qualifier marks the failing transaction as posted
// RQ21 - 48-bit completion header packed address, count, TC, attr, ID, tag
// RQ22 - unsupported request report is ignored while fifo ready is deasserted
// RQ23 - user holds one access stable until done
// RQ24 - each error report lasts one cycle with qualifiers valid
`timescale 1ns/10ps
`include "csm_map.vh"

module csm_cfg_mgmt #(
  parameter        FIFO_DEPTH = `CSM_FIFO_DEPTH,
  parameter        FIFO_PTR_W = `CSM_FIFO_PTR_W,
  parameter [31:0] ID_WORD    = `CSM_CFG_ID_VALUE  // arbitrary identity value
) (
  input  wire                        ref_clk,
  input  wire                        rst_n,
  input  wire [3:0]                  mgmt_byte_en_n,
  input  wire [31:0]                 mgmt_wr_data,
  output reg  [31:0]                 mgmt_rd_data,
  input  wire [`CSM_CFG_ADDR_W-1:0]  mgmt_dword_addr,
  input  wire                        mgmt_rd_en_n,
  input  wire                        mgmt_wr_en_n,
  output reg                         mgmt_access_done_n,
  input  wire                        mgmt_wr_ro_override_n,
  input  wire                        mgmt_wr_w1c_as_rw_n,
  input  wire                        err_acs_violation_n,
  input  wire [127:0]                err_adv_header_log,
  output reg                         err_adv_header_log_set_n,
  input  wire                        err_correctable_n,
  input  wire                        err_cpl_aborted_n,
  output reg                         err_cpl_hdr_fifo_ready_n,
  input  wire                        err_cpl_timed_out_n,
  input  wire                        err_cpl_unexpected_n,
  input  wire                        err_end_to_end_crc_n,
  input  wire                        err_locked_qual_n,
  input  wire                        err_posted_qual_n,
  input  wire [`CSM_HDR_W-1:0]       err_cpl_header,
  input  wire                        err_unsupported_req_n,
  input  wire [`CSM_AV_ADDR_W-1:0]   avs_address,
  input  wire                        avs_read,
  input  wire                        avs_write,
  input  wire [31:0]                 avs_writedata,
  input  wire [3:0]                  avs_byteenable,
  output reg  [31:0]                 avs_readdata,
  output reg                         avs_waitrequest
);
  localparam RAM_AW  = `CSM_CFG_RAM_AW;
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_REST = 3'b100;

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  // active-low byte enables widened to a bit mask
  function [31:0] beMask;
    input [3:0] beN;
    begin
      beMask = {{8{~beN[3]}}, {8{~beN[2]}}, {8{~beN[1]}}, {8{~beN[0]}}};
    end
  endfunction

  // dwords past the store are reserved: read zero, never written
  function inStore;
    input [`CSM_CFG_ADDR_W-1:0] a;
    begin
      inStore = (a[`CSM_CFG_ADDR_W-1:RAM_AW] == {(`CSM_CFG_ADDR_W-RAM_AW){1'b0}});
    end
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg  [2:0]               stateReg;
  reg  [2:0]               stateNext;
  reg  [`CSM_ERR_BITS-1:0] errStatReg;
  reg  [`CSM_ERR_BITS-1:0] errStatNext;
  reg                      rdRamReg;
  reg                      rdErrReg;
  reg                      rdIdReg;

  wire        rdReq = ~mgmt_rd_en_n;  // RQ5
  wire        wrReq = ~mgmt_wr_en_n;  // RQ6
  wire        idle  = (stateReg == ST_IDLE);
  wire [31:0] wMask = beMask(mgmt_byte_en_n);  // RQ1
  wire        roOvr = ~mgmt_wr_ro_override_n;
  wire        w1cRw = ~mgmt_wr_w1c_as_rw_n;
  wire        aInSt = inStore(mgmt_dword_addr);
  wire        aErr  = (mgmt_dword_addr == `CSM_CFG_ERR_STAT_DW);
  wire        aId   = (mgmt_dword_addr == `CSM_CFG_ID_DW);
  wire        aRo   = (mgmt_dword_addr < `CSM_CFG_RO_TOP);
  wire        wrGo  = idle && wrReq;
  wire        rdGo  = idle && rdReq && !wrReq;

  // --------------------------------------------------------------------------
  // configuration store
  // --------------------------------------------------------------------------
  // identity is fixed even under override; status word lives in flops
  wire        ramWe = wrGo && aInSt && !aErr && !aId && (!aRo || roOvr);  // RQ8
  wire        ramRe = rdGo && aInSt;
  wire [31:0] ramRd;

  csm_cfg_ram #(
    .ADDR_W (RAM_AW)
  ) uRam (
    .ref_clk (ref_clk),
    .wrEn    (ramWe),                          // RQ2
    .byteEn  (~mgmt_byte_en_n),
    .addr    (mgmt_dword_addr[RAM_AW-1:0]),    // RQ4
    .wrData  (mgmt_wr_data),
    .rdEn    (ramRe),
    .rdData  (ramRd)
  );

  // --------------------------------------------------------------------------
  // error reports
  // --------------------------------------------------------------------------
  // reports needing a completion are dropped while the fifo is full
  wire fifoRoom = ~err_cpl_hdr_fifo_ready_n;
  wire abortAcc = ~err_cpl_aborted_n && fifoRoom;      // RQ14
  wire urAcc    = ~err_unsupported_req_n && fifoRoom;  // RQ22
  wire posted   = ~err_posted_qual_n;                  // RQ20
  wire locked   = ~err_locked_qual_n;                  // RQ19

  // posted requests get no completion, so nothing is queued for them
  wire                   hdrPush = (abortAcc || urAcc) && !posted;
  wire [`CSM_ENT_W-1:0]  hdrEnt  = {urAcc, locked, err_cpl_header};  // RQ19 RQ21
  wire [`CSM_ENT_W-1:0]  hdrHead;
  wire                   fifoFull;
  wire                   fifoEmpty;
  wire [FIFO_PTR_W:0]    fifoCount;
  wire                   hdrPop;

  // internal set events for the W1C status word
  wire [`CSM_ERR_BITS-1:0] errSet;
  assign errSet[`CSM_ERR_COR]     = ~err_correctable_n;     // RQ13
  assign errSet[`CSM_ERR_ACS]     = ~err_acs_violation_n;   // RQ11
  assign errSet[`CSM_ERR_ECRC]    = ~err_end_to_end_crc_n;  // RQ18
  assign errSet[`CSM_ERR_ABORT]   = abortAcc;               // RQ14
  assign errSet[`CSM_ERR_TIMEOUT] = ~err_cpl_timed_out_n;   // RQ16
  assign errSet[`CSM_ERR_UNEXP]   = ~err_cpl_unexpected_n;  // RQ17
  assign errSet[`CSM_ERR_UR]      = urAcc;                  // RQ22

  csm_hdr_fifo #(
    .WIDTH (`CSM_ENT_W),
    .DEPTH (FIFO_DEPTH),
    .PTR_W (FIFO_PTR_W)
  ) uFifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .push     (hdrPush),
    .pushData (hdrEnt),
    .pop      (hdrPop),
    .headData (hdrHead),
    .fullReg  (fifoFull),
    .emptyReg (fifoEmpty),
    .countReg (fifoCount)
  );

  // occupancy after this edge; ready must drop in the edge that fills the last slot,
  // else a report one cycle later would be taken with nowhere to queue its header
  wire [FIFO_PTR_W:0] cntAfter = fifoCount
                                 + {{FIFO_PTR_W{1'b0}}, (hdrPush && !fifoFull)}
                                 - {{FIFO_PTR_W{1'b0}}, (hdrPop && !fifoEmpty)};

  // status word: W1C clear or direct store, then sets override clears
  always @* begin
    errStatNext = errStatReg;
    if (wrGo && aErr) begin
      if (w1cRw) begin
        errStatNext = (errStatReg & ~wMask[`CSM_ERR_BITS-1:0]) |
                      (mgmt_wr_data[`CSM_ERR_BITS-1:0] & wMask[`CSM_ERR_BITS-1:0]);  // RQ10
      end else begin
        errStatNext = errStatReg &
                      ~(mgmt_wr_data[`CSM_ERR_BITS-1:0] & wMask[`CSM_ERR_BITS-1:0]);  // RQ9
      end
    end
    errStatNext = errStatNext | errSet;  // RQ9
  end

  // --------------------------------------------------------------------------
  // access sequencer
  // --------------------------------------------------------------------------
  // rest state skips the cycle where the user still holds a stale enable
  always @* begin
    stateNext = stateReg;
    case (stateReg)
      ST_IDLE: begin
        if (wrGo) begin
          stateNext = ST_REST;
        end else if (rdGo) begin
          stateNext = ST_READ;
        end
      end
      ST_READ: begin
        stateNext = ST_REST;
      end
      ST_REST: begin
        stateNext = ST_IDLE;
      end
      default: begin
        stateNext = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      stateReg                 <= ST_IDLE;
      errStatReg               <= `CSM_ERR_RESET;
      rdRamReg                 <= 1'b0;
      rdErrReg                 <= 1'b0;
      rdIdReg                  <= 1'b0;
      mgmt_rd_data             <= 32'h0000_0000;
      mgmt_access_done_n       <= 1'b1;
      err_adv_header_log_set_n <= 1'b1;  // output has no function
      err_cpl_hdr_fifo_ready_n <= 1'b1;
    end else begin
      stateReg                 <= stateNext;
      errStatReg               <= errStatNext;
      err_adv_header_log_set_n <= 1'b1;
      err_cpl_hdr_fifo_ready_n <= (cntAfter == FIFO_DEPTH[FIFO_PTR_W:0]);  // RQ15
      if (rdGo) begin
        rdRamReg <= aInSt && !aErr && !aId;
        rdErrReg <= aErr;
        rdIdReg  <= aId;
      end
      // done marks a write in the same edge, a read one edge later
      mgmt_access_done_n <= ~(wrGo || (stateReg == ST_READ));  // RQ7
      if (stateReg == ST_READ) begin
        if (rdRamReg) begin
          mgmt_rd_data <= ramRd;  // RQ3
        end else if (rdErrReg) begin
          mgmt_rd_data <= {{(32-`CSM_ERR_BITS){1'b0}}, errStatReg};  // RQ3
        end else if (rdIdReg) begin
          mgmt_rd_data <= ID_WORD;
        end else begin
          mgmt_rd_data <= 32'h0000_0000;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // avalon slave: status view and header drain
  // --------------------------------------------------------------------------
  // one wait cycle, then a single-cycle answer; writes act on that edge
  wire avAck = (avs_read || avs_write) && avs_waitrequest;
  assign hdrPop = avs_write && !avs_waitrequest && (avs_address == `CSM_AV_CTRL) &&
                  avs_byteenable[0] && avs_writedata[`CSM_AV_CTRL_POP];

  reg [31:0] avRdNext;
  always @* begin
    avRdNext = 32'h0000_0000;
    case (avs_address)
      `CSM_AV_ERR_STAT: begin
        avRdNext[`CSM_ERR_BITS-1:0] = errStatReg;
      end
      `CSM_AV_HDR_LO: begin
        avRdNext = hdrHead[31:0];
      end
      `CSM_AV_HDR_HI: begin
        avRdNext[15:0]             = hdrHead[`CSM_HDR_W-1:32];
        avRdNext[`CSM_AV_HI_LOCK]  = hdrHead[`CSM_ENT_LOCK];
        avRdNext[`CSM_AV_HI_UR]    = hdrHead[`CSM_ENT_UR];
        avRdNext[`CSM_AV_HI_VALID] = ~fifoEmpty;
      end
      `CSM_AV_CTRL: begin
        avRdNext[FIFO_PTR_W:0] = fifoCount;
      end
      default: begin
        avRdNext = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~avAck;
      if (avAck && avs_read) begin
        avs_readdata <= avRdNext;
      end
    end
  end
endmodule

// ===== csm_cfg_mgmt_props.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// port checks for the management, error and avalon ports
// ----------------------------------------------------------------------------
module csm_cfg_mgmt_props (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        mgmt_rd_en_n,
  input wire        mgmt_wr_en_n,
  input wire        mgmt_access_done_n,
  input wire [31:0] mgmt_rd_data,
  input wire        err_cpl_aborted_n,
  input wire        err_unsupported_req_n,
  input wire        err_posted_qual_n,
  input wire        err_cpl_hdr_fifo_ready_n,
  input wire        err_adv_header_log_set_n,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // a non-posted abort or ur taken while there is room queues one header
  wire pushReq = (!err_cpl_aborted_n || !err_unsupported_req_n) && err_posted_qual_n
                 && !err_cpl_hdr_fifo_ready_n;
  property p_done_pulse;
    !mgmt_access_done_n |=> mgmt_access_done_n;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_wr_done;
    $fell(mgmt_wr_en_n) |=> !mgmt_access_done_n;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write done late");
  property p_rd_done;
    $fell(mgmt_rd_en_n) && mgmt_wr_en_n |=> mgmt_access_done_n ##1 !mgmt_access_done_n;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read done timing wrong");
  property p_no_idle_done;
    mgmt_rd_en_n && mgmt_wr_en_n && $past(mgmt_rd_en_n) && $past(mgmt_wr_en_n)
      |=> mgmt_access_done_n;
  endproperty
  a_no_idle_done: assert property (p_no_idle_done) else $error("done without request");
  property p_rd_hold;
    $changed(mgmt_rd_data) |-> !mgmt_access_done_n;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without done");
  property p_ready_fall;
    $fell(err_cpl_hdr_fifo_ready_n) |-> !$past(rst_n, 2) || $past(avs_write)
      || $past(avs_write, 2) || $past(avs_write, 3);
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready without pop");
  property p_ready_rise;
    $rose(err_cpl_hdr_fifo_ready_n) |-> $past(pushReq) || $past(pushReq, 2);
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready dropped without push");
  property p_log_set;
    err_adv_header_log_set_n;
  endproperty
  a_log_set: assert property (p_log_set) else $error("log set output active");
  property p_av_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_av_wait: assert property (p_av_wait) else $error("avalon answer late");
  c_wr: cover property ($fell(mgmt_wr_en_n));
  c_rd: cover property ($fell(mgmt_rd_en_n));
  c_full: cover property ($rose(err_cpl_hdr_fifo_ready_n));
endmodule

// ===== csm_user_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// user logic issuing management accesses
// ----------------------------------------------------------------------------
module csm_user_model (
  input  wire        ref_clk,
  input  wire        doneN,
  input  wire [31:0] rdData,
  output reg         rdEnN,
  output reg         wrEnN,
  output reg  [9:0]  addr,
  output reg  [31:0] wrData,
  output reg  [3:0]  byteEnN,
  output reg         roN,
  output reg         w1cN
);
  // parked at time zero with no request
  initial begin
    rdEnN = 1'b1;
    wrEnN = 1'b1;
    addr = 10'h3ff;
    wrData = 32'h0;
    byteEnN = 4'hf;
    roN = 1'b1;
    w1cN = 1'b1;
  end
  // one access held until done; released address, data and byte enables carry inverted values
  task access(input wr, input [9:0] a, input [31:0] d, input [3:0] be, input ro,
              input w1c, output [31:0] q, output tmo);
    integer n;
    begin
      tmo = 1'b1;
      q = 32'h0;
      @(posedge ref_clk);
      rdEnN <= wr;
      wrEnN <= !wr;
      addr <= a;
      wrData <= d;
      byteEnN <= be;
      roN <= ro;
      w1cN <= w1c;
      for (n = 0; n < 20 && tmo; n = n + 1) begin
        @(posedge ref_clk);
        if (doneN === 1'b0) begin
          tmo = 1'b0;
          q = rdData;
        end
      end
      rdEnN <= 1'b1;
      wrEnN <= 1'b1;
      addr <= ~a;
      wrData <= ~d;
      byteEnN <= ~be;
      roN <= 1'b1;
      w1cN <= 1'b1;
    end
  endtask
endmodule

// ===== csm_cfg_mgmt_bench.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// self-checking bench
// ----------------------------------------------------------------------------
module csm_cfg_mgmt_bench;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [6:0]  errN = 7'h7f;
  reg         lockN = 1'b1;
  reg         postN = 1'b1;
  reg  [47:0] hdr = 48'h0;
  reg  [2:0]  avAddr = 3'h0;
  reg         avRd = 1'b0;
  reg         avWr = 1'b0;
  reg  [31:0] avWrData = 32'h0;
  reg  [3:0]  avBe = 4'h0;
  reg  [31:0] q;
  reg  [47:0] h;
  wire        doneN, rdEnN, wrEnN, roN, w1cN, readyN, logSetN, avWait;
  wire [31:0] rdData, wrData, avRdData;
  wire [9:0]  addr;
  wire [3:0]  beN;
  integer     errCount = 0;
  integer     comparisons = 0;
  integer     i;
  always #2 ref_clk = ~ref_clk;
  csm_cfg_mgmt dut (.ref_clk(ref_clk), .rst_n(rst_n), .mgmt_byte_en_n(beN),
    .mgmt_wr_data(wrData), .mgmt_rd_data(rdData), .mgmt_dword_addr(addr),
    .mgmt_rd_en_n(rdEnN), .mgmt_wr_en_n(wrEnN), .mgmt_access_done_n(doneN),
    .mgmt_wr_ro_override_n(roN), .mgmt_wr_w1c_as_rw_n(w1cN),
    .err_acs_violation_n(errN[1]), .err_adv_header_log(128'h0),
    .err_adv_header_log_set_n(logSetN), .err_correctable_n(errN[0]),
    .err_cpl_aborted_n(errN[3]), .err_cpl_hdr_fifo_ready_n(readyN),
    .err_cpl_timed_out_n(errN[4]), .err_cpl_unexpected_n(errN[5]),
    .err_end_to_end_crc_n(errN[2]), .err_locked_qual_n(lockN), .err_posted_qual_n(postN),
    .err_cpl_header(hdr), .err_unsupported_req_n(errN[6]), .avs_address(avAddr),
    .avs_read(avRd), .avs_write(avWr), .avs_writedata(avWrData), .avs_byteenable(avBe),
    .avs_readdata(avRdData), .avs_waitrequest(avWait));
  csm_user_model u_user (.ref_clk(ref_clk), .doneN(doneN), .rdData(rdData), .rdEnN(rdEnN),
    .wrEnN(wrEnN), .addr(addr), .wrData(wrData), .byteEnN(beN), .roN(roN), .w1cN(w1cN));
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errCount = errCount + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // mgmt accesses through the user model; a hang ends the run
  task mw(input [9:0] a, input [31:0] d, input [3:0] be, input ro, input w1c);
    reg tmo;
    begin
      u_user.access(1'b1, a, d, be, ro, w1c, q, tmo);
      if (tmo) begin errCount = errCount + 1; stop_test; end
    end
  endtask
  task mr(input [9:0] a, input [31:0] exp);
    reg tmo;
    begin
      u_user.access(1'b0, a, 32'h0, 4'h0, 1'b1, 1'b1, q, tmo);
      if (tmo) begin errCount = errCount + 1; stop_test; end
      chk(q, exp);
    end
  endtask
  // avalon cycle held until waitrequest is sampled low
  task av(input wr, input [2:0] a, input [31:0] d);
    integer n;
    reg got;
    begin
      got = 1'b0;
      @(posedge ref_clk);
      avRd <= !wr;
      avWr <= wr;
      avAddr <= a;
      avWrData <= d;
      avBe <= 4'hf;
      for (n = 0; n < 20 && !got; n = n + 1) begin
        @(posedge ref_clk);
        if (avWait === 1'b0) begin got = 1'b1; q = avRdData; end
      end
      avRd <= 1'b0;
      avWr <= 1'b0;
      avAddr <= ~a;
      avWrData <= ~d;
      if (!got) begin errCount = errCount + 1; stop_test; end
    end
  endtask
  // one-cycle error report; released header shows inverted bits
  task rep(input [6:0] n, input lk, input po, input [47:0] hd);
    begin
      @(posedge ref_clk);
      errN <= n;
      lockN <= lk;
      postN <= po;
      hdr <= hd;
      @(posedge ref_clk);
      errN <= 7'h7f;
      lockN <= 1'b1;
      postN <= 1'b1;
      hdr <= ~hd;
    end
  endtask
  function [47:0] hdf(input integer k);
    hdf = {k[6:0] + 7'h05, 12'h004, 3'h1, 2'h2, 16'h0abc, k[7:0] + 8'h10};
  endfunction
  task t_reset;
    begin
      chk({29'h0, doneN, logSetN, avWait}, 32'h7);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, readyN}, 32'h0);
    end
  endtask
  task t_rw;
    begin
      mw(10'h010, 32'h1234_5678, 4'h0, 1'b1, 1'b1);
      mr(10'h010, 32'h1234_5678);
      mw(10'h010, 32'hffff_ffff, 4'ha, 1'b1, 1'b1);
      mr(10'h010, 32'h12ff_56ff);
      mw(10'h000, 32'h0, 4'h0, 1'b0, 1'b1);
      mr(10'h000, 32'h0a5a_0c3e);
      mw(10'h005, 32'ha5, 4'h0, 1'b1, 1'b1);
      mr(10'h005, 32'h0);
      mw(10'h005, 32'ha5, 4'h0, 1'b0, 1'b1);
      mr(10'h005, 32'ha5);
      mr(10'h100, 32'h0);
    end
  endtask
  // posted reports set status only; clear each by writing one
  task t_err;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        rep(~(7'h1 << i), 1'b1, 1'b0, 48'h0);
        mr(10'h040, 32'h1 << i);
        mw(10'h040, 32'h1 << i, 4'h0, 1'b1, 1'b1);
        mr(10'h040, 32'h0);
      end
      mw(10'h040, 32'h7f, 4'h0, 1'b1, 1'b0);
      mr(10'h040, 32'h7f);
      av(1'b0, 3'h0, 32'h0);
      chk(q, 32'h7f);
      mw(10'h040, 32'h7f, 4'h0, 1'b1, 1'b1);
    end
  endtask
  // fill the header fifo, get refused, then drain one entry
  task t_fifo;
    begin
      for (i = 0; i < 3; i = i + 1) rep(7'h3f, i != 1, 1'b1, hdf(i));
      // last ur, then an abort in the very next cycle that must meet ready high
      @(posedge ref_clk);
      errN <= 7'h3f;
      hdr <= hdf(3);
      @(posedge ref_clk);
      errN <= 7'h77;
      @(posedge ref_clk);
      errN <= 7'h7f;
      repeat (3) @(posedge ref_clk);
      chk({31'h0, readyN}, 32'h1);
      mr(10'h040, 32'h40);
      mw(10'h040, 32'h7f, 4'h0, 1'b1, 1'b1);
      rep(7'h3f, 1'b1, 1'b1, hdf(7));
      rep(7'h77, 1'b1, 1'b1, hdf(7));
      mr(10'h040, 32'h0);
      av(1'b0, 3'h3, 32'h0);
      chk(q, 32'h4);
      h = hdf(0);
      av(1'b0, 3'h1, 32'h0);
      chk(q, h[31:0]);
      av(1'b0, 3'h2, 32'h0);
      chk(q, {1'b1, 13'h0, 1'b1, 1'b0, h[47:32]});
      av(1'b1, 3'h3, 32'h1);
      h = hdf(1);
      av(1'b0, 3'h2, 32'h0);
      chk(q, {1'b1, 13'h0, 1'b1, 1'b1, h[47:32]});
      repeat (3) @(posedge ref_clk);
      chk({31'h0, readyN}, 32'h0);
      av(1'b0, 3'h5, 32'h0);
      chk(q, 32'h0);
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_rw;
    t_err;
    t_fifo;
    stop_test;
  end
endmodule
bind csm_cfg_mgmt csm_cfg_mgmt_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .mgmt_rd_en_n(mgmt_rd_en_n), .mgmt_wr_en_n(mgmt_wr_en_n),
  .mgmt_access_done_n(mgmt_access_done_n), .mgmt_rd_data(mgmt_rd_data),
  .err_cpl_aborted_n(err_cpl_aborted_n), .err_unsupported_req_n(err_unsupported_req_n),
  .err_posted_qual_n(err_posted_qual_n), .err_cpl_hdr_fifo_ready_n(err_cpl_hdr_fifo_ready_n),
  .err_adv_header_log_set_n(err_adv_header_log_set_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
